//--- hdl/vtac_pkg.sv
// Constants for the vector table offset and application control register block
// Notes on behaviour
// - Bit 29 picks code or SRAM region
// - Bits 28..7 hold read/write table offset
// - Control writes need key 0x5FA on top
// - Control reads return 0xFA05 in top half
// - Bit 15 reports byte order, 1 big
// - Split code n: 7-n pre-emption bits
// - Split applies to every priority field
// - Only top three priority bits exist
// - Clear-active bit erases active state, self-clears
// - Reset request bit raises request until reset
// - Local reset bit pulses reset, self-clears
package vtac_pkg;

  // Register map, byte offsets within the block
  localparam int unsigned      ADDR_W         = 12;
  localparam logic [11:0]      OFF_VTOR       = 12'h008;
  localparam logic [11:0]      OFF_AIRCR      = 12'h00C;

  // Table offset register fields
  localparam int unsigned      REGION_BIT     = 29;
  localparam int unsigned      TOFF_HI        = 28;
  localparam int unsigned      TOFF_LO        = 7;
  localparam int unsigned      TOFF_W         = TOFF_HI - TOFF_LO + 1;
  localparam logic             REGION_RST     = 1'b0;
  localparam logic [21:0]      TOFF_RST       = 22'h000000;

  // Application control register fields
  localparam int unsigned      KEY_HI         = 31;
  localparam int unsigned      KEY_LO         = 16;
  localparam logic [15:0]      KEY_WRITE      = 16'h05FA;
  localparam logic [15:0]      KEY_STATUS     = 16'hFA05;
  localparam int unsigned      ORDER_BIT      = 15;
  localparam int unsigned      GRP_HI         = 10;
  localparam int unsigned      GRP_LO         = 8;
  localparam int unsigned      GRP_W          = 3;
  localparam logic [2:0]       GRP_RST        = 3'h0;
  localparam int unsigned      SYSRST_BIT     = 2;
  localparam int unsigned      CLRACT_BIT     = 1;
  localparam int unsigned      LOCRST_BIT     = 0;

  // Priority slot layout
  localparam int unsigned      PRI_W          = 8;
  localparam int unsigned      PRI_IMPL       = 3;

  // Bus answer states, Gray order
  typedef enum logic [0:0] {
    VTAC_ST_IDLE = 1'b0,
    VTAC_ST_ANSW = 1'b1
  } vtac_state_e;

endpackage

//--- hdl/vtac_prio_split.sv
// One priority slot split into pre-emption and subpriority parts
`timescale 1ns/1ps
`default_nettype none
module vtac_prio_split
  import vtac_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [PRI_W-1:0] slot,       // Raw 8-bit priority slot
  input  wire logic [GRP_W-1:0] grp,        // Priority split code
  output logic      [PRI_W-1:0] preempt_r,  // Bits that compare as pre-emption
  output logic      [PRI_W-1:0] sub_r       // Bits used only for ordering
);

  logic [PRI_W-1:0] impl_slot;    // Slot with unimplemented bits forced low
  logic [PRI_W-1:0] pre_mask;     // One where a bit is pre-emption
  logic [PRI_W-1:0] preempt_nxt;
  logic [PRI_W-1:0] sub_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // Masking and split
  always_comb begin
    // Low bits have no storage behind them, so they never take part
    impl_slot = {slot[PRI_W-1 -: PRI_IMPL], {(PRI_W-PRI_IMPL){1'b0}}};
    for (int i = 0; i < PRI_W; i++) begin
      pre_mask[i] = (4'(i) > {1'b0, grp});
    end
    preempt_nxt = impl_slot & pre_mask;
    sub_nxt     = impl_slot & ~pre_mask;
  end

  // Register the split so that outputs are clean flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preempt_r <= 8'h00;
      sub_r     <= 8'h00;
    end else begin
      preempt_r <= preempt_nxt;
      sub_r     <= sub_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_split_low_zero: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ((preempt_r | sub_r) & 8'h1F) == 8'h00)
    else $error("unimplemented priority bits leaked");

  // The first edge after release still shows the reset image, so skip it
  chk_split_partition: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> ((preempt_r & sub_r) == 8'h00) && ((preempt_r | sub_r) == {$past(slot[7:5]), 5'h00})
      && ((preempt_r & (8'hFF >> (7 - $past(grp)))) == 8'h00))
    else $error("priority split wrong for grouping code");

endmodule
`default_nettype wire

//--- hdl/vtac_regs.sv
// Vector table offset and application interrupt and reset control registers on APB
`timescale 1ns/1ps
`default_nettype none
module vtac_regs
  import vtac_pkg::*;
#(
  parameter int unsigned NUM_PRI = 4          // Priority slots to split
)(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [ADDR_W-1:0]        paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     big_endian_strap,
  input  wire logic [NUM_PRI*PRI_W-1:0] pri_slots,
  output logic                          table_region_select,
  output logic      [TOFF_W-1:0]        table_offset_field,
  output logic                          byte_order_bit,
  output logic      [GRP_W-1:0]         priority_split_field,
  output logic                          system_reset_request,
  output logic                          clear_active_state,
  output logic                          local_system_reset,
  output logic      [NUM_PRI*PRI_W-1:0] preempt_level,
  output logic      [NUM_PRI*PRI_W-1:0] sub_level
);

  // Elaboration check on the slot count
  if (NUM_PRI < 1 || NUM_PRI > 240) begin : g_bad_num_pri
    $error("NUM_PRI out of range");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  vtac_state_e       state_r, state_nxt;          // Bus answer state
  logic [31:0]       prdata_r, prdata_nxt;        // Read data, latched with pready
  logic              pready_r, pready_nxt;
  logic              pslverr_r, pslverr_nxt;
  logic              region_r, region_nxt;        // Code or SRAM region
  logic [TOFF_W-1:0] toff_r, toff_nxt;            // Table offset field
  logic              order_r, order_nxt;          // Byte order, from strap
  logic              strap_taken_r;               // Strap caught once after reset
  logic [GRP_W-1:0]  grp_r, grp_nxt;              // Priority split code
  logic              sysrst_r, sysrst_nxt;        // Held reset request
  logic              clract_r, clract_nxt;        // One-cycle clear pulse
  logic              locrst_r, locrst_nxt;        // One-cycle local reset pulse

  logic              hit_vtor;                    // Address decodes
  logic              hit_aircr;
  logic              commit;                      // Completing edge of a transfer
  logic              wr_vtor;
  logic              wr_aircr;                    // Write with correct key
  logic              key_ok;
  logic [GRP_W-1:0]  wr_grp;                      // Written split code
  logic              wr_region;                   // Written region bit
  logic [31:0]       vtor_view;                   // Read images
  logic [31:0]       aircr_view;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode and read images
  always_comb begin
    hit_vtor   = (paddr == OFF_VTOR);
    hit_aircr  = (paddr == OFF_AIRCR);
    commit     = (state_r == VTAC_ST_ANSW) && psel && penable;
    key_ok     = (pwdata[KEY_HI:KEY_LO] == KEY_WRITE);
    wr_vtor    = commit && pwrite && hit_vtor;
    wr_aircr   = commit && pwrite && hit_aircr && key_ok;
    wr_grp     = pwdata[GRP_HI:GRP_LO];
    wr_region  = pwdata[REGION_BIT];
    // Reserved bits are simply never wired to storage
    vtor_view  = {2'b00, region_r, toff_r, 7'h00};
    // Action bits are pulses or held requests and read back as zero
    aircr_view = {KEY_STATUS, order_r, 4'h0, grp_r, 8'h00};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus answer: one wait cycle, then pready for the completing edge
  always_comb begin
    state_nxt   = state_r;
    prdata_nxt  = prdata_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    case (state_r)
      VTAC_ST_IDLE: begin
        // Access phase seen: prepare the answer
        if (psel && penable) begin
          state_nxt   = VTAC_ST_ANSW;
          pready_nxt  = 1'b1;
          pslverr_nxt = !(hit_vtor || hit_aircr);
          prdata_nxt  = hit_vtor ? vtor_view : (hit_aircr ? aircr_view : 32'h00000000);
        end
      end
      VTAC_ST_ANSW: begin
        // Transfer completes on this edge
        state_nxt = VTAC_ST_IDLE;
      end
      default: begin
        state_nxt = VTAC_ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register field updates
  always_comb begin
    region_nxt = region_r;
    toff_nxt   = toff_r;
    grp_nxt    = grp_r;
    sysrst_nxt = sysrst_r;
    clract_nxt = 1'b0;
    locrst_nxt = 1'b0;
    // Strap is read only once it has been sampled after release
    order_nxt  = strap_taken_r ? order_r : big_endian_strap;
    if (wr_vtor) begin
      region_nxt = wr_region;
      toff_nxt   = pwdata[TOFF_HI:TOFF_LO];
    end
    // Alignment of the offset is the writer's duty; no check here
    if (wr_aircr) begin
      grp_nxt    = wr_grp;
      clract_nxt = pwdata[CLRACT_BIT];
      locrst_nxt = pwdata[LOCRST_BIT];
      // Held until the warm reset that it causes arrives on presetn
      sysrst_nxt = sysrst_r | pwdata[SYSRST_BIT];
    end
  end

  // All state flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r       <= VTAC_ST_IDLE;
      prdata_r      <= 32'h00000000;
      pready_r      <= 1'b0;
      pslverr_r     <= 1'b0;
      region_r      <= REGION_RST;
      toff_r        <= TOFF_RST;
      order_r       <= 1'b0;
      strap_taken_r <= 1'b0;
      grp_r         <= GRP_RST;
      sysrst_r      <= 1'b0;
      clract_r      <= 1'b0;
      locrst_r      <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      prdata_r      <= prdata_nxt;
      pready_r      <= pready_nxt;
      pslverr_r     <= pslverr_nxt;
      region_r      <= region_nxt;
      toff_r        <= toff_nxt;
      order_r       <= order_nxt;
      strap_taken_r <= 1'b1;
      grp_r         <= grp_nxt;
      sysrst_r      <= sysrst_nxt;
      clract_r      <= clract_nxt;
      locrst_r      <= locrst_nxt;
    end
  end

  // Outputs straight from flops
  assign prdata               = prdata_r;
  assign pready               = pready_r;
  assign pslverr              = pslverr_r;
  assign table_region_select  = region_r;
  assign table_offset_field   = toff_r;
  assign byte_order_bit       = order_r;
  assign priority_split_field = grp_r;
  assign system_reset_request = sysrst_r;
  assign clear_active_state   = clract_r;
  assign local_system_reset   = locrst_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Per-slot priority split
  for (genvar g = 0; g < NUM_PRI; g++) begin : g_split
    vtac_prio_split u_split (
      .pclk      (pclk),
      .presetn   (presetn),
      .slot      (pri_slots[g*PRI_W +: PRI_W]),
      .grp       (grp_r),
      .preempt_r (preempt_level[g*PRI_W +: PRI_W]),
      .sub_r     (sub_level[g*PRI_W +: PRI_W])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_key_guard: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && pwrite && hit_aircr && !key_ok) |=> $stable(grp_r) && $stable(sysrst_r)
      && !clract_r && !locrst_r)
    else $error("keyless control write changed state");

  chk_key_update: assert property (@(posedge pclk) disable iff (!presetn)
    wr_aircr |=> (grp_r == $past(wr_grp)))
    else $error("keyed write did not load split code");

  chk_key_readback: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && hit_aircr && !pwrite) |-> (prdata[KEY_HI:KEY_LO] == KEY_STATUS) && (prdata[14:11] == 4'h0)
      && (prdata[7:0] == 8'h00))
    else $error("control readback wrong");

  chk_vtor_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && hit_vtor && !pwrite) |-> (prdata[31:30] == 2'b00) && (prdata[6:0] == 7'h00))
    else $error("table offset reserved bits not zero");

  chk_vtor_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_vtor |=> (table_region_select == $past(wr_region)))
    else $error("region bit not stored");

  chk_clear_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_aircr && pwdata[CLRACT_BIT]) |=> clear_active_state ##1 !clear_active_state)
    else $error("clear-active is not a one-cycle pulse");

  chk_locrst_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_aircr && pwdata[LOCRST_BIT]) |=> local_system_reset ##1 !local_system_reset)
    else $error("local reset is not a one-cycle pulse");

  chk_sysreset_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_aircr && pwdata[SYSRST_BIT]) |=> system_reset_request [*4])
    else $error("reset request not held");

  chk_ready_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held more than one cycle");

endmodule
`default_nettype wire

//--- tb/vtac_regs_tb.sv
// Self-checking bench for the vector table offset and application control registers
`timescale 1ns/1ps
`default_nettype none
module vtac_regs_tb;
  import vtac_pkg::*;
  localparam int NP = 4;                               // Priority slots under test
  logic                pclk, presetn, psel, penable, pwrite, big_endian_strap;
  logic [ADDR_W-1:0]   paddr;                          // Byte address
  logic [31:0]         pwdata, prdata, rd;             // Bus data and last read
  logic                pready, pslverr, er;            // Answer and last error
  logic                table_region_select, byte_order_bit, system_reset_request;
  logic                clear_active_state, local_system_reset;
  logic [TOFF_W-1:0]   table_offset_field;
  logic [GRP_W-1:0]    priority_split_field;
  logic [NP*PRI_W-1:0] pri_slots, preempt_level, sub_level;
  int                  error_cnt = 0, n_tests = 0, cyc = 0, clr_cnt = 0, loc_cnt = 0;
  logic [2:0]          exp_grp = 3'h0;                 // Split code the bench expects

  vtac_regs #(.NUM_PRI(NP)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .big_endian_strap(big_endian_strap), .pri_slots(pri_slots),
    .table_region_select(table_region_select), .table_offset_field(table_offset_field),
    .byte_order_bit(byte_order_bit), .priority_split_field(priority_split_field),
    .system_reset_request(system_reset_request), .clear_active_state(clear_active_state),
    .local_system_reset(local_system_reset), .preempt_level(preempt_level), .sub_level(sub_level));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, hang guard and pulse counters
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Whole run needs well under 1000 cycles; a hang ends here
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  // Counting pulse cycles catches both a missing and a stretched pulse
  always @(posedge pclk) begin
    if (clear_active_state === 1'b1) clr_cnt++;
    if (local_system_reset === 1'b1) loc_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No assumed latency: only the global cycle limit ends a wait that never completes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [31:0] ctl_read(input logic strap, input logic [2:0] g);
    return {KEY_STATUS, strap, 4'h0, g, 8'h00};
  endfunction

  // Expected split of every slot; only bits 7:5 of a slot exist
  function automatic logic [31:0] split_exp(input logic [31:0] s, input int n, input bit pre);
    logic [8:0] m;
    logic [31:0] r;
    m = (9'h001 << (n + 1)) - 9'h001;
    for (int g = 0; g < NP; g++) r[8*g+:8] = (s[8*g+:8] & 8'hE0) & (pre ? ~m[7:0] : m[7:0]);
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_values();
    chk_word(32'(byte_order_bit), 32'h1);
    apb(1'b0, OFF_VTOR, 32'h0);
    chk_word(rd, 32'h0);
    apb(1'b0, OFF_AIRCR, 32'h0);
    chk_word(rd, ctl_read(1'b1, 3'h0));
  endtask

  task automatic t_offset();
    apb(1'b1, OFF_VTOR, 32'hFFFF_FFFF);
    apb(1'b0, OFF_VTOR, 32'h0);
    chk_word(rd, 32'h3FFF_FF80);
    chk_word(32'(table_region_select), 32'h1);
    apb(1'b1, OFF_VTOR, 32'h1000_0080);
    chk_word(32'(er), 32'h0);
    apb(1'b0, OFF_VTOR, 32'h0);
    chk_word(rd, 32'h1000_0080);
    chk_word(32'(table_region_select), 32'h0);
    chk_word(32'(table_offset_field), 32'h0020_0001);
  endtask

  // Every split code; reserved bits 14:11 and the byte order bit are written high too
  task automatic t_split();
    for (int n = 0; n < 8; n++) begin
      apb(1'b1, OFF_AIRCR, {KEY_WRITE, 16'hF800} | (32'(n) << 8));
      exp_grp = 3'(n);
      apb(1'b0, OFF_AIRCR, 32'h0);
      chk_word(rd, ctl_read(1'b1, exp_grp));
      chk_word(preempt_level, split_exp(pri_slots, n, 1'b1));
      chk_word(sub_level, split_exp(pri_slots, n, 1'b0));
    end
  endtask

  // Wrong keys, the readback value among them, change nothing
  task automatic t_keyless();
    logic [15:0] bad [2] = '{16'hFA05, 16'h05FB};
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, OFF_AIRCR, {bad[i], 16'h0207});
      repeat (2) @(posedge pclk);
      chk_word(32'(priority_split_field), 32'(exp_grp));
      chk_word(clr_cnt + loc_cnt, 0);
      chk_word(32'(system_reset_request), 32'h0);
    end
  endtask

  task automatic t_pulses();
    apb(1'b1, OFF_AIRCR, {KEY_WRITE, 5'h0, exp_grp, 8'h02});
    apb(1'b1, OFF_AIRCR, {KEY_WRITE, 5'h0, exp_grp, 8'h01});
    apb(1'b0, OFF_AIRCR, 32'h0);
    chk_word(rd, ctl_read(1'b1, exp_grp));
    chk_word(clr_cnt, 1);
    chk_word(loc_cnt, 1);
  endtask

  task automatic t_unmapped();
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    chk_word(32'(er), 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk_word({rd[31:1], er}, 32'h1);
    apb(1'b0, OFF_VTOR, 32'h0);
    chk_word(rd, 32'h1000_0080);
  endtask

  // Request holds until the warm reset, which also brings the strap in again
  task automatic t_sysreset();
    apb(1'b1, OFF_AIRCR, {KEY_WRITE, 5'h0, exp_grp, 8'h04});
    repeat (5) @(posedge pclk);
    chk_word(32'(system_reset_request), 32'h1);
    presetn <= 1'b0;
    big_endian_strap <= 1'b0;
    repeat (10) @(posedge pclk);
    chk_word(32'(system_reset_request), 32'h0);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk_word(32'(byte_order_bit), 32'h0);
    apb(1'b0, OFF_AIRCR, 32'h0);
    chk_word(rd, ctl_read(1'b0, 3'h0));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and main sequence
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    big_endian_strap = 1'b1;
    pri_slots = 32'hFFBF_7F3F;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset_values();
    t_offset();
    t_split();
    t_keyless();
    t_pulses();
    t_unmapped();
    t_sysreset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
